// >>> als_defines.vh
// constants for the light sensor register bank
// Summary of operation
// R01: every register is sixteen bits wide and always accessed whole.
// R02: pointer 00h result, 01h configuration, 02h lower limit, 03h upper limit.
// R03: read-only maker identifier at 7Eh and part identifier at 7Fh.
// R04: result holds exponent in bits 15:12 and mantissa in bits 11:0.
// R05: mantissa is straight binary; result resets to zero exponent and mantissa.
// R06: one count weighs 0.02 lux times two to the exponent.
// R07: mask bit with manual range code reports result exponent as zero.
// R08: configuration write aborts any measurement in progress at once.
// R09: configuration write starts a new conversion when the new mode asks.
// R10: configuration resets to c810h, automatic range, long integration.
// R11: configuration field layout: range, time, mode, status flags, control bits.
// R12: range code uses the same code to range mapping as the exponent.
// R13: range code 1100b selects range automatically and reports it in exponent.
// R14: range field holds 1100 after power-up.
// R15: host never writes reserved range codes 1101b, 1110b or 1111b.
// R16: limit registers hold exponent on top and twelve-bit mantissa below.
// R17: write is pointer byte then two data bytes, each byte acknowledged.
// R18: sixteen-bit words travel upper byte first, then lower byte.
// R19: mode 00 shutdown, 01 single-shot, 10 or 11 continuous.
// R20: writes to read-only bits or registers are accepted but change nothing.
`ifndef ALS_DEFINES_VH
`define ALS_DEFINES_VH
// ==========================================
// register pointers
`define ALS_PTR_RESULT 8'h00
`define ALS_PTR_CONFIG 8'h01
`define ALS_PTR_LOWER 8'h02
`define ALS_PTR_UPPER 8'h03
`define ALS_PTR_MAKER 8'h7e
`define ALS_PTR_PART 8'h7f
// ==========================================
// configuration field positions
`define ALS_CFG_RANGE_HI 15
`define ALS_CFG_RANGE_LO 12
`define ALS_CFG_CT 11
`define ALS_CFG_MODE_HI 10
`define ALS_CFG_MODE_LO 9
`define ALS_CFG_OVF 8
`define ALS_CFG_DONE 7
`define ALS_CFG_ABOVE 6
`define ALS_CFG_BELOW 5
`define ALS_CFG_LATCH 4
`define ALS_CFG_POL 3
`define ALS_CFG_MASK 2
`define ALS_CFG_FC_HI 1
`define ALS_CFG_FC_LO 0
// writable bits of configuration: 15:9 and 4:0
`define ALS_CFG_WR_MASK 16'hfe1f
// ==========================================
// reset values and codes
`define ALS_CFG_RESET 16'hc810
`define ALS_RESULT_RESET 16'h0000
`define ALS_LOWER_RESET 16'h0000
`define ALS_UPPER_RESET 16'hbfff
`define ALS_RANGE_AUTO 4'hc
`define ALS_MODE_OFF 2'h0
`define ALS_MODE_SINGLE 2'h1
`endif

// >>> als_reg_bank.v
// register bank of the ambient light sensor, byte port and converter control
`timescale 1ns/10ps
`include "als_defines.vh"
module als_reg_bank #(
   parameter [15:0] MAKER_ID = 16'h1234, // arbitrary value
   parameter [15:0] PART_ID = 16'h5678 // arbitrary value
) (
   // clock and reset
   input wire sys_clk_i,
   input wire arst_n_i,
   // write side of the serial engine
   input wire wr_start_i,
   input wire wr_byte_valid_i,
   input wire [7:0] wr_byte_i,
   // read side of the serial engine
   input wire rd_start_i,
   input wire rd_byte_ack_i,
   output reg [7:0] rd_byte_o,
   // converter results
   input wire conv_done_i,
   input wire [3:0] conv_exponent_i,
   input wire [11:0] conv_mantissa_i,
   input wire overrange_i,
   input wire above_limit_i,
   input wire below_limit_i,
   // converter control
   output reg conv_start_o,
   output reg conv_abort_o,
   output reg conv_busy_o,
   output wire [3:0] range_code_o,
   output wire integration_length_sel_o,
   output wire alert_latch_o,
   output wire alert_polarity_o,
   output wire [1:0] fault_count_sel_o,
   output wire [15:0] lower_alert_threshold_o,
   output wire [15:0] upper_alert_threshold_o
);
   // ==========================================
   // write sequencer states
   localparam [3:0] WR_IDLE = 4'b0001;
   localparam [3:0] WR_PTR = 4'b0010;
   localparam [3:0] WR_HI = 4'b0100;
   localparam [3:0] WR_LO = 4'b1000;

   reg [3:0] wr_state;
   reg [7:0] reg_ptr;
   reg [7:0] wr_hi_byte;
   reg [15:0] conversion_result;
   reg [15:0] operating_config;
   reg [15:0] lower_alert_threshold;
   reg [15:0] upper_alert_threshold;
   reg [15:0] rd_shadow;
   reg rd_low_next;
   reg [15:0] rd_word;
   reg [15:0] next_config;
   reg [3:0] next_exponent;
   wire wr_commit;
   wire cfg_write;
   wire [3:0] range_code;
   wire exponent_mask_en;

   assign range_code = operating_config[`ALS_CFG_RANGE_HI:`ALS_CFG_RANGE_LO];
   assign exponent_mask_en = operating_config[`ALS_CFG_MASK];

   // ==========================================
   // control outputs straight from the registers
   assign range_code_o = range_code; // [R12]
   assign integration_length_sel_o = operating_config[`ALS_CFG_CT];
   assign alert_latch_o = operating_config[`ALS_CFG_LATCH];
   assign alert_polarity_o = operating_config[`ALS_CFG_POL];
   assign fault_count_sel_o = operating_config[`ALS_CFG_FC_HI:`ALS_CFG_FC_LO];
   assign lower_alert_threshold_o = lower_alert_threshold;
   assign upper_alert_threshold_o = upper_alert_threshold;

   // ==========================================
   // write sequencer: pointer byte, upper byte, lower byte
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_state <= WR_IDLE;
         reg_ptr <= 8'h00;
         wr_hi_byte <= 8'h00;
      end else if (wr_start_i) begin
         wr_state <= WR_PTR; // [R17]
      end else if (wr_byte_valid_i) begin
         case (wr_state)
            WR_PTR: begin
               reg_ptr <= wr_byte_i; // pointer kept for later reads [R17]
               wr_state <= WR_HI;
            end
            WR_HI: begin
               wr_hi_byte <= wr_byte_i; // upper byte first [R18]
               wr_state <= WR_LO;
            end
            WR_LO: begin
               wr_state <= WR_IDLE; // extra bytes ignored
            end
            WR_IDLE: begin
               wr_state <= WR_IDLE;
            end
            default: begin
               wr_state <= WR_IDLE;
            end
         endcase
      end
   end

   // full word lands only with the lower byte [R01]
   assign wr_commit = wr_byte_valid_i && !wr_start_i && (wr_state == WR_LO);
   assign cfg_write = wr_commit && (reg_ptr == `ALS_PTR_CONFIG); // [R02]

   // ==========================================
   // new configuration: writable bits from bus, read-only bits kept
   always @* begin
      next_config = (operating_config & ~`ALS_CFG_WR_MASK) |
                    ({wr_hi_byte, wr_byte_i} & `ALS_CFG_WR_MASK); // [R11] [R20]
   end

   // ==========================================
   // exponent reported with a finished conversion
   always @* begin
      if (range_code == `ALS_RANGE_AUTO) begin
         next_exponent = conv_exponent_i; // chosen range reported [R13]
      end else if (exponent_mask_en) begin
         next_exponent = 4'h0; // masked in manual range [R07]
      end else begin
         next_exponent = range_code; // same mapping as exponent [R12] [R06]
      end
   end

   // ==========================================
   // limit registers
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lower_alert_threshold <= `ALS_LOWER_RESET;
         upper_alert_threshold <= `ALS_UPPER_RESET;
      end else if (wr_commit) begin
         if (reg_ptr == `ALS_PTR_LOWER) begin
            lower_alert_threshold <= {wr_hi_byte, wr_byte_i}; // [R16] [R02]
         end
         if (reg_ptr == `ALS_PTR_UPPER) begin
            upper_alert_threshold <= {wr_hi_byte, wr_byte_i}; // [R16] [R02]
         end
      end
   end

   // ==========================================
   // configuration, result and conversion control
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         operating_config <= `ALS_CFG_RESET; // [R10] [R14]
         conversion_result <= `ALS_RESULT_RESET; // [R05]
         conv_start_o <= 1'b0;
         conv_abort_o <= 1'b0;
         conv_busy_o <= 1'b0;
      end else begin
         conv_start_o <= 1'b0;
         conv_abort_o <= 1'b0;
         if (cfg_write) begin
            // a write beats a conversion ending in the same cycle
            operating_config <= next_config;
            conv_abort_o <= conv_busy_o; // [R08]
            if (next_config[`ALS_CFG_MODE_HI:`ALS_CFG_MODE_LO] != `ALS_MODE_OFF) begin
               conv_start_o <= 1'b1; // [R09] [R19]
               conv_busy_o <= 1'b1;
            end else begin
               conv_busy_o <= 1'b0; // shutdown [R19]
            end
         end else if (conv_done_i && conv_busy_o) begin
            conversion_result <= {next_exponent, conv_mantissa_i}; // [R04] [R05]
            operating_config[`ALS_CFG_OVF] <= overrange_i;
            operating_config[`ALS_CFG_DONE] <= 1'b1;
            operating_config[`ALS_CFG_ABOVE] <= above_limit_i;
            operating_config[`ALS_CFG_BELOW] <= below_limit_i;
            if (operating_config[`ALS_CFG_MODE_HI:`ALS_CFG_MODE_LO] == `ALS_MODE_SINGLE) begin
               // single shot falls back to shutdown [R19]
               operating_config[`ALS_CFG_MODE_HI:`ALS_CFG_MODE_LO] <= `ALS_MODE_OFF;
               conv_busy_o <= 1'b0;
            end else begin
               conv_start_o <= 1'b1; // continuous restarts [R19]
            end
         end
      end
   end

   // ==========================================
   // read mux, unmapped pointers read zero
   always @* begin
      case (reg_ptr)
         `ALS_PTR_RESULT: rd_word = conversion_result; // [R04]
         `ALS_PTR_CONFIG: rd_word = operating_config;
         `ALS_PTR_LOWER: rd_word = lower_alert_threshold;
         `ALS_PTR_UPPER: rd_word = upper_alert_threshold;
         `ALS_PTR_MAKER: rd_word = MAKER_ID; // [R03]
         `ALS_PTR_PART: rd_word = PART_ID; // [R03]
         default: rd_word = 16'h0000;
      endcase
   end

   // ==========================================
   // read byte stream, word snapshot keeps both bytes coherent
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_shadow <= 16'h0000;
         rd_low_next <= 1'b0;
         rd_byte_o <= 8'h00;
      end else if (rd_start_i) begin
         rd_shadow <= rd_word; // [R01]
         rd_byte_o <= rd_word[15:8]; // upper byte first [R18]
         rd_low_next <= 1'b1;
      end else if (rd_byte_ack_i) begin
         if (rd_low_next) begin
            rd_byte_o <= rd_shadow[7:0]; // [R18]
            rd_low_next <= 1'b0;
         end else begin
            rd_shadow <= rd_word;
            rd_byte_o <= rd_word[15:8];
            rd_low_next <= 1'b1;
         end
      end
   end
endmodule // als_reg_bank

// >>> als_reg_bank_props.sv
// checker for the light sensor register bank
`timescale 1ns/10ps
module als_reg_bank_props (
   // clock and reset
   input wire sys_clk_i,
   input wire arst_n_i,
   // byte port
   input wire wr_start_i,
   input wire wr_byte_valid_i,
   input wire [7:0] wr_byte_i,
   input wire rd_start_i,
   input wire rd_byte_ack_i,
   input wire [7:0] rd_byte_o,
   // converter side
   input wire conv_done_i,
   input wire conv_start_o,
   input wire conv_abort_o,
   input wire conv_busy_o,
   input wire [3:0] range_code_o,
   input wire integration_length_sel_o,
   input wire [15:0] lower_alert_threshold_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // ==========================
   // complete write of the lower limit
   sequence s_lower_wr;
      wr_start_i ##1 (wr_byte_valid_i && wr_byte_i == 8'h02) ##1 wr_byte_valid_i [*2];
   endsequence
   chk_lower_limit_write: assert property (s_lower_wr |=>
      lower_alert_threshold_o == {$past(wr_byte_i, 2), $past(wr_byte_i)}) else $error("lower limit not stored");
   chk_reset_auto_range: assert property ($rose(arst_n_i) |->
      range_code_o == 4'hc && integration_length_sel_o) else $error("config not at reset value");
   chk_abort_cause: assert property (conv_abort_o |->
      $past(conv_busy_o) && $past(wr_byte_valid_i)) else $error("abort without busy write");
   chk_start_cause: assert property (conv_start_o |->
      $past(wr_byte_valid_i) || $past(conv_done_i)) else $error("start without cause");
   chk_start_then_busy: assert property (conv_start_o |=> conv_busy_o && !conv_start_o)
      else $error("start not followed by busy");
   chk_read_byte_holds: assert property (!rd_start_i && !rd_byte_ack_i |=> $stable(rd_byte_o))
      else $error("read byte moved");
   chk_limit_holds: assert property (!wr_byte_valid_i |=> $stable(lower_alert_threshold_o))
      else $error("limit moved without write");
   chk_config_holds: assert property (!wr_byte_valid_i |=>
      $stable(range_code_o) && $stable(integration_length_sel_o)) else $error("config moved without write");
endmodule // als_reg_bank_props
bind als_reg_bank als_reg_bank_props als_reg_bank_props_inst (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
   .wr_start_i(wr_start_i), .wr_byte_valid_i(wr_byte_valid_i), .wr_byte_i(wr_byte_i), .rd_start_i(rd_start_i),
   .rd_byte_ack_i(rd_byte_ack_i), .rd_byte_o(rd_byte_o), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
   .conv_abort_o(conv_abort_o), .conv_busy_o(conv_busy_o), .range_code_o(range_code_o),
   .integration_length_sel_o(integration_length_sel_o), .lower_alert_threshold_o(lower_alert_threshold_o));

// >>> als_host_model.sv
// host controller model driving the byte port
`timescale 1ns/10ps
module als_host_model (
   // clock
   input wire sys_clk_i,
   // byte port towards the bank
   output reg wr_start_o,
   output reg wr_byte_valid_o,
   output reg [7:0] wr_byte_o,
   output reg rd_start_o,
   output reg rd_byte_ack_o,
   input wire [7:0] rd_byte_i
);
   initial begin
      {wr_start_o, wr_byte_valid_o, wr_byte_o, rd_start_o, rd_byte_ack_o} = 12'h000;
   end
   // pointer byte, then upper and lower data bytes when full
   task wr_reg(input [7:0] ptr, input [15:0] d, input full);
      begin
         @(negedge sys_clk_i) wr_start_o = 1'b1;
         @(negedge sys_clk_i) {wr_start_o, wr_byte_valid_o, wr_byte_o} = {2'b01, ptr};
         if (full) begin
            @(negedge sys_clk_i) wr_byte_o = d[15:8];
            @(negedge sys_clk_i) wr_byte_o = d[7:0];
         end
         @(negedge sys_clk_i) wr_byte_valid_o = 1'b0;
         wr_byte_o = ~wr_byte_o; // released lines show no stale byte
      end
   endtask
   // pointer-only write, then two bytes read upper first
   task rd_reg(input [7:0] ptr, output [15:0] d);
      begin
         wr_reg(ptr, 16'h0000, 1'b0);
         @(negedge sys_clk_i) rd_start_o = 1'b1;
         @(negedge sys_clk_i) rd_start_o = 1'b0;
         d[15:8] = rd_byte_i;
         rd_byte_ack_o = 1'b1;
         @(negedge sys_clk_i) rd_byte_ack_o = 1'b0;
         d[7:0] = rd_byte_i;
      end
   endtask
endmodule // als_host_model

// >>> als_reg_bank_tb_top.sv
// testbench of the light sensor register bank
`timescale 1ns/10ps
module als_reg_bank_tb_top;
   reg sys_clk_i, arst_n_i, conv_done_i, overrange_i, above_limit_i, below_limit_i;
   reg [3:0] conv_exponent_i;
   reg [11:0] conv_mantissa_i;
   reg [15:0] d;
   reg [15:0] starts = 16'h0000;
   reg [15:0] aborts = 16'h0000;
   wire wr_start_i, wr_byte_valid_i, rd_start_i, rd_byte_ack_i, conv_start_o, conv_abort_o;
   wire conv_busy_o, integration_length_sel_o;
   wire [3:0] range_code_o;
   wire [7:0] wr_byte_i, rd_byte_o;
   wire [15:0] lower_alert_threshold_o, upper_alert_threshold_o;
   integer err_count, checked;
   integer cycles = 0;
   als_host_model als_host_model_inst (.sys_clk_i(sys_clk_i), .wr_start_o(wr_start_i),
      .wr_byte_valid_o(wr_byte_valid_i), .wr_byte_o(wr_byte_i), .rd_start_o(rd_start_i),
      .rd_byte_ack_o(rd_byte_ack_i), .rd_byte_i(rd_byte_o));
   als_reg_bank als_reg_bank_inst (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .wr_start_i(wr_start_i),
      .wr_byte_valid_i(wr_byte_valid_i), .wr_byte_i(wr_byte_i), .rd_start_i(rd_start_i),
      .rd_byte_ack_i(rd_byte_ack_i), .rd_byte_o(rd_byte_o), .conv_done_i(conv_done_i),
      .conv_exponent_i(conv_exponent_i), .conv_mantissa_i(conv_mantissa_i), .overrange_i(overrange_i),
      .above_limit_i(above_limit_i), .below_limit_i(below_limit_i), .conv_start_o(conv_start_o),
      .conv_abort_o(conv_abort_o), .conv_busy_o(conv_busy_o), .range_code_o(range_code_o),
      .integration_length_sel_o(integration_length_sel_o), .alert_latch_o(), .alert_polarity_o(),
      .fault_count_sel_o(), .lower_alert_threshold_o(lower_alert_threshold_o),
      .upper_alert_threshold_o(upper_alert_threshold_o));
   task end_sim;
      begin
         $display("mismatches %0d comparisons %0d", err_count, checked);
         if (err_count == 0 && checked > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk16(input [15:0] got, input [15:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rd_chk(input [7:0] ptr, input [15:0] exp);
      begin
         als_host_model_inst.rd_reg(ptr, d);
         chk16(d, exp);
      end
   endtask
   task wr(input [7:0] ptr, input [15:0] v);
      als_host_model_inst.wr_reg(ptr, v, 1'b1);
   endtask
   // converter finishes: data valid one cycle, then scrambled
   task conv(input [3:0] e, input [11:0] m, input [2:0] f);
      begin
         @(negedge sys_clk_i) conv_done_i = 1'b1;
         {conv_exponent_i, conv_mantissa_i, overrange_i, above_limit_i, below_limit_i} = {e, m, f};
         @(negedge sys_clk_i) conv_done_i = 1'b0;
         {conv_exponent_i, conv_mantissa_i} = ~{e, m};
      end
   endtask
   // ==========================
   // clock
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // converter pulse counts and hang limit
   always @(posedge sys_clk_i) begin
      starts <= starts + {15'h0000, conv_start_o};
      aborts <= aborts + {15'h0000, conv_abort_o};
      cycles = cycles + 1;
      if (cycles == 3000) begin
         err_count = err_count + 1;
         end_sim;
      end
   end
   // ==========================
   // test sequence
   initial begin
      {arst_n_i, conv_done_i, overrange_i, above_limit_i, below_limit_i} = 5'h00;
      {conv_exponent_i, conv_mantissa_i} = 16'h0000;
      {err_count, checked} = 0;
      repeat (12) @(negedge sys_clk_i);
      arst_n_i = 1'b1;
      rd_chk(8'h01, 16'hc810);
      chk16({12'h000, range_code_o}, 16'h000c);
      chk16({15'h0000, integration_length_sel_o}, 16'h0001);
      chk16({15'h0000, conv_busy_o}, 16'h0000);
      rd_chk(8'h00, 16'h0000);
      rd_chk(8'h7e, 16'h1234);
      rd_chk(8'h7f, 16'h5678);
      rd_chk(8'h55, 16'h0000);
      wr(8'h7f, 16'hffff);
      rd_chk(8'h7f, 16'h5678);
      wr(8'h00, 16'hffff);
      rd_chk(8'h00, 16'h0000);
      wr(8'h02, 16'h5abc);
      rd_chk(8'h02, 16'h5abc);
      chk16(lower_alert_threshold_o, 16'h5abc);
      wr(8'h03, 16'ha123);
      rd_chk(8'h03, 16'ha123);
      chk16(upper_alert_threshold_o, 16'ha123);
      // single shot, manual range 3, masked exponent, read-only bits poked
      wr(8'h01, 16'h33e4); // legal range code only
      rd_chk(8'h01, 16'h3204);
      chk16({12'h000, range_code_o}, 16'h0003);
      chk16({15'h0000, conv_busy_o}, 16'h0001);
      conv(4'h5, 12'h456, 3'b110);
      rd_chk(8'h00, 16'h0456);
      rd_chk(8'h01, 16'h31c4);
      chk16({15'h0000, conv_busy_o}, 16'h0000);
      // single shot, manual range 7, exponent from the range code
      wr(8'h01, 16'h7200); // legal range code only
      conv(4'h2, 12'hfff, 3'b001);
      rd_chk(8'h00, 16'h7fff);
      rd_chk(8'h01, 16'h70a0);
      // continuous automatic range ignores the mask, then shutdown aborts
      wr(8'h01, 16'hc404); // legal range code only
      conv(4'hb, 12'h001, 3'b000);
      rd_chk(8'h00, 16'hb001);
      chk16({15'h0000, conv_busy_o}, 16'h0001);
      wr(8'h01, 16'hc004); // legal range code only
      @(negedge sys_clk_i);
      chk16(starts, 16'h0004);
      chk16(aborts, 16'h0001);
      end_sim;
   end
endmodule // als_reg_bank_tb_top
